// ### csba_top.sv
// module: receive-stage buffer, snapshot buffer and host read path for channel status
`timescale 1ns/10ps
`default_nettype none

module csba_top (
    input wire logic i_mclk,                      // 250 MHz system clock
    input wire logic i_nrst,                      // synchronous reset, active low
    input wire csba_pkg::csba_frame_type i_frame, // decoded frame from receiver logic
    input wire logic i_output_frame_clock,        // output frame clock pin
    input wire csba_pkg::csba_port_type i_port,   // control port access
    output logic [7:0] o_rdata,                   // read data, valid cycle after rd
    output logic o_irq,                           // transfer interrupt, level
    output logic o_copy_permit,                   // copy permitted pin
    output logic o_original_source_pin,           // original source pin
    output logic o_serial_status                  // serial channel status output
);
    // --------------------------------------------------------------------
    // storage
    // --------------------------------------------------------------------
    logic [7:0] recv_buf [csba_pkg::CSBA_NUM_BYTES];  // receive-stage buffer
    logic [7:0] snap_buf [csba_pkg::CSBA_NUM_BYTES];  // readable snapshot buffer
    logic [7:0] bit_idx;        // frame index inside current block
    logic block_ok;             // block started at its first frame, no partial fill
    logic [7:0] ctrl2;          // control register 2
    logic [7:0] irq_en;         // interrupt enable
    logic irq_stat;             // sticky transfer flag
    logic block_end;            // last frame of a complete block
    logic [7:0] fill_idx;       // position of the frame being written; a start frame is position zero
    logic fill_en;              // this strobe belongs to a block that began with its start frame
    logic do_xfer;              // copy happens this cycle
    logic [191:0] ser_block;    // full block of channel a status for serial out
    logic [191:0] ser_shift;    // serial shift register
    logic [7:0] ser_cnt;        // bits remaining
    logic ofc_s1, ofc_s2, ofc_s3; // frame clock synchroniser and edge history

    assign block_end = i_frame.strobe && block_ok && (bit_idx == csba_pkg::CSBA_LAST_BIT);
    // inhibit holds snapshot; next complete block after clear resumes
    assign do_xfer = block_end && !ctrl2[csba_pkg::CSBA_CTRL2_INHIBIT_BIT];

    // --------------------------------------------------------------------
    // block position tracking
    // --------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            bit_idx <= 8'h00;
            block_ok <= 1'b0;
        end
        else if (i_frame.strobe)
        begin
            if (i_frame.start)
            begin
                bit_idx <= 8'h01;
                block_ok <= 1'b1;   // a fill that began mid-block is never copied
            end
            else if (bit_idx == csba_pkg::CSBA_LAST_BIT)
            begin
                bit_idx <= 8'h00;
                block_ok <= 1'b0;   // wait for the next block start
            end
            else
            begin
                bit_idx <= bit_idx + 8'h01;
            end
        end
    end

    // --------------------------------------------------------------------
    // receive-stage fill: first forty bits per channel, msb first
    // --------------------------------------------------------------------
    // each generated process owns only its own two bytes, so no byte has two drivers
    assign fill_idx = i_frame.start ? 8'h00 : bit_idx;
    assign fill_en = i_frame.strobe && (i_frame.start || block_ok);
    for (genvar g = 0; g < csba_pkg::CSBA_BYTES_PER_CH; g++)
    begin : g_fill
        always_ff @(posedge i_mclk)
        begin
            if (!i_nrst)
            begin
                recv_buf[g] <= 8'h00;
                recv_buf[g + csba_pkg::CSBA_BYTES_PER_CH] <= 8'h00;
            end
            else if (fill_en && fill_idx[7:3] == 5'(g))
            begin
                // earliest bit lands in the msb
                recv_buf[g][3'd7 - fill_idx[2:0]] <= i_frame.bit_a;
                recv_buf[g + csba_pkg::CSBA_BYTES_PER_CH][3'd7 - fill_idx[2:0]] <= i_frame.bit_b;
            end
        end
    end

    // --------------------------------------------------------------------
    // whole-block copy into the snapshot
    // --------------------------------------------------------------------
    // the copy happens once per 192 frames, leaving the host that long to read
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            for (int k = 0; k < csba_pkg::CSBA_NUM_BYTES; k++)
                snap_buf[k] <= 8'h00;
        end
        else if (do_xfer)
        begin
            for (int k = 0; k < csba_pkg::CSBA_NUM_BYTES; k++)
                snap_buf[k] <= recv_buf[k];
        end
    end

    // --------------------------------------------------------------------
    // control registers and interrupt
    // --------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            ctrl2 <= csba_pkg::CSBA_CTRL2_RESET;
            irq_en <= csba_pkg::CSBA_IRQEN_RESET;
        end
        else if (i_port.wr)
        begin
            if (i_port.addr == csba_pkg::CSBA_ADDR_CTRL2)
                ctrl2 <= i_port.wdata;
            else if (i_port.addr == csba_pkg::CSBA_ADDR_IRQEN)
                irq_en <= i_port.wdata;
        end
    end

    // sticky flag: set wins over the read-to-clear in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            irq_stat <= 1'b0;
        else if (do_xfer)
            irq_stat <= 1'b1;
        else if (i_port.rd && i_port.addr == csba_pkg::CSBA_ADDR_IRQST)
            irq_stat <= 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            o_irq <= 1'b0;
        else
            o_irq <= (irq_stat || do_xfer) && irq_en[0];
    end

    // --------------------------------------------------------------------
    // read path: snapshot always visible
    // --------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            o_rdata <= 8'h00;
        else if (i_port.rd)
        begin
            if (i_port.addr >= csba_pkg::CSBA_ADDR_SNAP0 &&
                i_port.addr < csba_pkg::CSBA_ADDR_SNAP0 + 8'(csba_pkg::CSBA_NUM_BYTES))
                o_rdata <= snap_buf[4'(i_port.addr - csba_pkg::CSBA_ADDR_SNAP0)];
            else if (i_port.addr == csba_pkg::CSBA_ADDR_CTRL2)
                o_rdata <= ctrl2;
            else if (i_port.addr == csba_pkg::CSBA_ADDR_IRQEN)
                o_rdata <= irq_en;
            else if (i_port.addr == csba_pkg::CSBA_ADDR_IRQST)
                o_rdata <= {7'h00, irq_stat};
            else
                o_rdata <= 8'h00;  // unmapped reads as zero
        end
    end

    // --------------------------------------------------------------------
    // full serial stream and hardware-mode copy pins
    // --------------------------------------------------------------------
    // whole block of channel a collected so the serial pin carries every bit
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            ser_block <= '0;
        else if (i_frame.strobe)
            ser_block <= {ser_block[190:0], i_frame.bit_a};
    end

    // pin is asynchronous: two flops before any logic looks at it
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            ofc_s1 <= 1'b0;
            ofc_s2 <= 1'b0;
            ofc_s3 <= 1'b0;
        end
        else
        begin
            ofc_s1 <= i_output_frame_clock;
            ofc_s2 <= ofc_s1;
            ofc_s3 <= ofc_s2;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            ser_shift <= '0;
            ser_cnt <= 8'h00;
        end
        else if (block_end)
        begin
            ser_shift <= {ser_block[190:0], i_frame.bit_a};
            ser_cnt <= csba_pkg::CSBA_LAST_BIT;
        end
        else if (ofc_s2 != ofc_s3 && ser_cnt != 8'h00)
        begin
            ser_shift <= {ser_shift[190:0], 1'b0};
            ser_cnt <= ser_cnt - 8'h01;
        end
    end

    // hardware mode always drives the serial line; the copy pins carry copy information only while the serial select bit is clear
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            o_copy_permit <= 1'b0;
            o_original_source_pin <= 1'b0;
            o_serial_status <= 1'b0;
        end
        else
        begin
            o_serial_status <= ctrl2[csba_pkg::CSBA_CTRL2_HWMODE_BIT] ? ser_shift[191] : 1'b0;
            if (ctrl2[csba_pkg::CSBA_CTRL2_HWMODE_BIT] && !ctrl2[csba_pkg::CSBA_CTRL2_SERSEL_BIT])
            begin
                o_copy_permit <= snap_buf[0][3'd7 - 3'(csba_pkg::CSBA_COPY_BIT)];
                o_original_source_pin <= snap_buf[csba_pkg::CSBA_GEN_BIT / 8][3'd7 - 3'(csba_pkg::CSBA_GEN_BIT % 8)];
            end
            else
            begin
                o_copy_permit <= 1'b0;
                o_original_source_pin <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    sequence s_block_done;
        block_end && !ctrl2[csba_pkg::CSBA_CTRL2_INHIBIT_BIT];
    endsequence

    a_snap_copy: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        s_block_done |=> snap_buf[0] == $past(recv_buf[0]))
        else $error("snapshot not copied at block end");
    a_inhibit_holds: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        ctrl2[csba_pkg::CSBA_CTRL2_INHIBIT_BIT] && !i_port.wr |=> $stable(snap_buf[0]))
        else $error("snapshot changed while inhibited");
    a_irq_on_copy: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s_block_done and irq_en[0]) |=> o_irq)
        else $error("no interrupt after copy");
    a_irq_masked: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !irq_en[0] |=> !o_irq)
        else $error("interrupt while disabled");
    a_ctrl2_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_port.wr && i_port.addr == csba_pkg::CSBA_ADDR_CTRL2 |=> ctrl2 == $past(i_port.wdata))
        else $error("control register 2 not written");
    a_snap_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_port.rd && i_port.addr == csba_pkg::CSBA_ADDR_SNAP0 |=> o_rdata == $past(snap_buf[0]))
        else $error("byte 0 read mismatch");
    a_xfer_spacing: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        do_xfer |=> !do_xfer [*8])
        else $error("transfers too close");
    a_serial_shift: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !block_end && ofc_s2 != ofc_s3 && ser_cnt != 8'h00 |=> ser_cnt == $past(ser_cnt) - 8'h01)
        else $error("serial shift missed an edge");
    a_pins_sw_mode: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !ctrl2[csba_pkg::CSBA_CTRL2_HWMODE_BIT] |=> !o_copy_permit && !o_serial_status)
        else $error("copy pins active in software mode");
endmodule
`default_nettype wire

// ### csba_pkg.sv
// package: constants and carrier types for the channel status buffer access block
package csba_pkg;
    // register map of the control port
    localparam logic [7:0] CSBA_ADDR_CTRL2 = 8'h02;       // second control register
    localparam logic [7:0] CSBA_ADDR_SNAP0 = 8'h19;       // snapshot byte 0
    localparam logic [7:0] CSBA_ADDR_IRQEN = 8'h03;       // transfer interrupt enable register
    localparam logic [7:0] CSBA_ADDR_IRQST = 8'h04;       // transfer interrupt status register
    // field positions
    localparam int CSBA_CTRL2_INHIBIT_BIT = 7;           // transfer inhibit bit in control register 2
    localparam int CSBA_CTRL2_HWMODE_BIT = 0;            // hardware mode select
    localparam int CSBA_CTRL2_SERSEL_BIT = 1;            // hardware mode: copy pins held low while set
    // reset values
    localparam logic [7:0] CSBA_CTRL2_RESET = 8'h00;     // control register 2 after reset
    localparam logic [7:0] CSBA_IRQEN_RESET = 8'h00;     // interrupt enable after reset
    // sizes and timing
    localparam int CSBA_BYTES_PER_CH = 5;                // stored bytes per channel
    localparam int CSBA_NUM_BYTES = 10;                  // both channels
    localparam int CSBA_BLOCK_FRAMES = 192;              // frames in one channel status block
    localparam logic [7:0] CSBA_LAST_BIT = 8'hBF;        // bit index of the last frame of a block
    localparam int CSBA_COPY_BIT = 2;                    // consumer copy bit index (byte 0)
    localparam int CSBA_GEN_BIT = 15;                    // generation bit index (byte 1 bit 0)

    // one received channel status frame: a bit for each subframe channel
    typedef struct packed {
        logic strobe;   // one-cycle pulse per frame
        logic start;    // first frame of a block
        logic bit_a;    // channel a status bit
        logic bit_b;    // channel b status bit
    } csba_frame_type;

    // control port access
    typedef struct packed {
        logic wr;          // write strobe
        logic rd;          // read strobe
        logic [7:0] addr;  // register address
        logic [7:0] wdata; // write data
    } csba_port_type;
endpackage

// ### csba_host.sv
// host model: microcontroller side of the control port
`timescale 1ns/10ps
`default_nettype none
module csba_host (
    input wire logic i_mclk,                   // system clock
    input wire logic [7:0] i_rdata,            // read data from the device
    output var csba_pkg::csba_port_type o_port // control port request
);
    // idle lines carry junk so that a stale address is never mistaken for a request
    initial o_port = '{1'b0, 1'b0, 8'hA5, 8'h5A};
    // one-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1 o_port = '{1'b1, 1'b0, a, d};
        @(posedge i_mclk);
        #1 o_port = '{1'b0, 1'b0, ~a, ~d}; // released lines do not keep their value
    endtask
    // one-cycle read strobe, data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        #1 o_port = '{1'b0, 1'b1, a, o_port.wdata};
        @(posedge i_mclk);
        #1 d = i_rdata;
        o_port = '{1'b0, 1'b0, ~a, ~o_port.wdata};
    endtask
    // host picks copy and generation bits out of the snapshot itself
    task automatic copy_info(output logic cp, output logic gen);
        logic [7:0] b;
        rd(csba_pkg::CSBA_ADDR_SNAP0, b);
        cp = b[5];
        rd(csba_pkg::CSBA_ADDR_SNAP0 + 8'h01, b);
        gen = b[0];
    endtask
endmodule
`default_nettype wire

// ### testbench.sv
// testbench: drives channel status frames and judges the host-visible results
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic i_mclk; // system clock
    logic i_nrst; // reset, active low
    csba_pkg::csba_frame_type i_frame; // frame input
    logic i_output_frame_clock; // output frame clock pin
    csba_pkg::csba_port_type port; // host request
    logic [7:0] o_rdata; // read data
    logic o_irq, o_copy_permit, o_original_source_pin, o_serial_status; // device outputs
    logic [7:0] r; // scratch read value
    logic cp, gen; // copy info seen by the host
    int failures = 0; // mismatch count
    int n_compared = 0; // comparison count
    int cycles = 0; // timeout counter
    csba_top i_csba_top (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_frame(i_frame),
        .i_output_frame_clock(i_output_frame_clock), .i_port(port), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_copy_permit(o_copy_permit), .o_original_source_pin(o_original_source_pin),
        .o_serial_status(o_serial_status));
    csba_host i_csba_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_port(port));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    // cut a hang short; all tests need well under this many cycles
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            failures++;
            summarize();
        end
    end
    // status bit patterns for the two channels, varied by p
    function automatic logic fa(input int p, input int n);
        return ((n * 7 + p) % 5) < 2;
    endfunction
    function automatic logic fb(input int p, input int n);
        return ((n * 3 + p) % 7) < 3;
    endfunction
    task automatic summarize();
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // frames n = first .. first+cnt-1; strobes three cycles apart, start only on frame 0
    task automatic frames(input int p, input int first, input int cnt);
        for (int n = first; n < first + cnt; n++)
        begin
            @(posedge i_mclk);
            #1 i_frame = '{1'b1, n == 0, fa(p, n), fb(p, n)};
            @(posedge i_mclk);
            #1 i_frame = '{1'b0, 1'b0, ~i_frame.bit_a, ~i_frame.bit_b};
            @(posedge i_mclk);
            #1;
        end
    endtask
    // read all ten snapshot bytes and compare with pattern p
    task automatic chk_snap(input int p);
        logic [7:0] e;
        for (int k = 0; k < csba_pkg::CSBA_NUM_BYTES; k++)
        begin
            for (int j = 0; j < 8; j++)
                e[7-j] = (k < csba_pkg::CSBA_BYTES_PER_CH) ? fa(p, 8 * k + j) : fb(p, 8 * (k - 5) + j);
            i_csba_host.rd(csba_pkg::CSBA_ADDR_SNAP0 + 8'(k), r);
            chk(r, e);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        i_csba_host.rd(csba_pkg::CSBA_ADDR_CTRL2, r);
        chk(r, csba_pkg::CSBA_CTRL2_RESET);
        i_csba_host.rd(csba_pkg::CSBA_ADDR_IRQEN, r);
        chk(r, csba_pkg::CSBA_IRQEN_RESET);
        i_csba_host.rd(8'h40, r);
        chk(r, 8'h00);
    endtask
    // interrupt only after the full block; host reads well within the quiet interval
    task automatic t_block();
        i_csba_host.wr(csba_pkg::CSBA_ADDR_IRQEN, 8'h01);
        frames(1, 0, 191);
        chk({7'h00, o_irq}, 8'h00);
        frames(1, 191, 1);
        chk({7'h00, o_irq}, 8'h01);
        chk_snap(1);
        i_csba_host.copy_info(cp, gen);
        chk({6'h00, cp, gen}, {6'h00, fa(1, 2), fa(1, 15)});
        i_csba_host.rd(csba_pkg::CSBA_ADDR_IRQST, r);
        chk(r, 8'h01);
        @(posedge i_mclk);
        #1 chk({7'h00, o_irq}, 8'h00);
    endtask
    // inhibit freezes the snapshot; the next whole block after clearing is copied
    task automatic t_inhibit();
        i_csba_host.wr(csba_pkg::CSBA_ADDR_CTRL2, 8'h80);
        i_csba_host.rd(csba_pkg::CSBA_ADDR_CTRL2, r);
        chk(r, 8'h80);
        i_csba_host.rd(8'h40, r);
        chk(r, 8'h00);
        frames(2, 0, 192);
        chk({7'h00, o_irq}, 8'h00);
        chk_snap(1);
        i_csba_host.rd(csba_pkg::CSBA_ADDR_IRQST, r);
        chk(r, 8'h00);
        i_csba_host.wr(csba_pkg::CSBA_ADDR_CTRL2, 8'h00);
        frames(2, 0, 192);
        chk({7'h00, o_irq}, 8'h01);
        chk_snap(2);
        i_csba_host.rd(csba_pkg::CSBA_ADDR_IRQST, r);
        chk(r, 8'h01);
    endtask
    // a block that never saw its start frame is not copied
    task automatic t_partial();
        frames(3, 1, 191);
        frames(3, 1, 4);
        chk({7'h00, o_irq}, 8'h00);
        chk_snap(2);
    endtask
    // hardware mode: copy pins, then serial output on both frame-clock edges
    task automatic t_hwmode();
        i_csba_host.wr(csba_pkg::CSBA_ADDR_CTRL2, 8'h01);
        frames(1, 0, 192);
        repeat (2) @(posedge i_mclk);
        #1 chk({6'h00, o_copy_permit, o_original_source_pin}, {6'h00, fa(1, 2), fa(1, 15)});
        i_csba_host.wr(csba_pkg::CSBA_ADDR_CTRL2, 8'h03);
        frames(4, 0, 192);
        repeat (3) @(posedge i_mclk);
        #1 chk({6'h00, o_copy_permit, o_serial_status}, {7'h00, fa(4, 0)});
        for (int b = 1; b < 3; b++)
        begin
            i_output_frame_clock = ~i_output_frame_clock;
            repeat (8) @(posedge i_mclk);
            #1 chk({7'h00, o_serial_status}, {7'h00, fa(4, b)});
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        i_nrst = 1'b0;
        i_frame = '0;
        i_output_frame_clock = 1'b0;
        repeat (2) @(posedge i_mclk);
        #1 i_nrst = 1'b1;
        t_reset();
        t_block();
        t_inhibit();
        t_partial();
        t_hwmode();
        summarize();
    end
endmodule
`default_nettype wire
